// file: hw/ram_block_pkg.sv
// Shared constants, carrier types and shape decoding for the embedded RAM block.
// Assumes one system clock; the section clocks arrive as sampled pins.
package ram_block_pkg;

	// Array geometry: 256 rows of 16 bits make up the whole store
	localparam int TOTAL_BITS = 4096;
	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 11;
	localparam int ROW_W      = 8;
	localparam int ROWS       = 256;

	// Word shapes
	localparam logic [1:0] SHAPE_256X16  = 2'h0;
	localparam logic [1:0] SHAPE_512X8   = 2'h1;
	localparam logic [1:0] SHAPE_1024X4  = 2'h2;
	localparam logic [1:0] SHAPE_2048X2  = 2'h3;

	// Configuration port offsets
	localparam logic [1:0] OFS_CFG       = 2'h0;
	localparam logic [1:0] OFS_INIT_ADDR = 2'h1;
	localparam logic [1:0] OFS_INIT_DATA = 2'h2;
	localparam logic [1:0] OFS_STATUS    = 2'h3;

	// Path register selects, bit positions inside cfg_t.regsel
	localparam int SEL_WDATA  = 0;
	localparam int SEL_DOUT   = 1;
	localparam int SEL_WRADDR = 2;
	localparam int SEL_WREN   = 3;
	localparam int SEL_RDADDR = 4;
	localparam int SEL_RDEN   = 5;
	localparam int CFG_W      = 11;

	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] FULL_MASK = 16'hffff;
	localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [ROW_W-1:0]  ROW_ZERO  = 8'h00;
	localparam logic [ROW_W-1:0]  ROW_ONE   = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
	localparam logic [3:0]        POS_ZERO  = 4'h0;

	typedef struct packed {
		logic [5:0] regsel;     // One bit per optionally registered path
		logic       rd_on_out;  // Read address/enable regs on output-side clock in dual-port mode
		logic       rom;        // User writes blocked, contents from init load
		logic       dual;       // Simple dual-port when set, single-port when clear
		logic [1:0] shape;
	} cfg_t;

	localparam cfg_t CFG_RESET = cfg_t'(11'h000);

	typedef struct packed {
		cfg_t               cfg;
		logic [ROW_W-1:0]   init_row;
		logic [ADDR_W-1:0]  wa_h;
		logic [DATA_W-1:0]  wd_h;
		logic               we_h;
		logic               wr_go;
		logic [ADDR_W-1:0]  ra_h;
		logic               re_h;
		logic [3:0]         rpos;
		logic [DATA_W-1:0]  q;
		logic [DATA_W-1:0]  rdata;
		logic [DATA_W-1:0]  wr_count;
	} top_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} sampler_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
	} mem_state_t;

	// Row of the physical array holding a logical word
	function automatic logic [ROW_W-1:0] row_of(input logic [1:0] shape, input logic [ADDR_W-1:0] addr);
		case (shape)
			SHAPE_256X16: row_of = addr[7:0];
			SHAPE_512X8:  row_of = addr[8:1];
			SHAPE_1024X4: row_of = addr[9:2];
			default:      row_of = addr[10:3];
		endcase
	endfunction

	// Bit position of a logical word inside its row
	function automatic logic [3:0] lane_pos(input logic [1:0] shape, input logic [ADDR_W-1:0] addr);
		case (shape)
			SHAPE_256X16: lane_pos = POS_ZERO;
			SHAPE_512X8:  lane_pos = {addr[0], 3'h0};
			SHAPE_1024X4: lane_pos = {addr[1:0], 2'h0};
			default:      lane_pos = {addr[2:0], 1'h0};
		endcase
	endfunction

	// Valid data bits for a shape
	function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] shape);
		case (shape)
			SHAPE_256X16: width_mask = 16'hffff;
			SHAPE_512X8:  width_mask = 16'h00ff;
			SHAPE_1024X4: width_mask = 16'h000f;
			default:      width_mask = 16'h0003;
		endcase
	endfunction

endpackage

// file: hw/pin_edge_sampler.sv
// Two-flop synchroniser and rising-edge detector for a section clock pin.
// Assumes the pin toggles slower than half the system clock rate.
`timescale 1ns/10ps
module pin_edge_sampler (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic ce,
	input  wire logic pin,
	output logic      rise
);
	ram_block_pkg::sampler_state_t st_reg;
	ram_block_pkg::sampler_state_t st_next;

	// s1 feeds s2 only; the edge is taken between s2 and s3
	always_comb
	begin
		st_next = st_reg;
		if (ce)
		begin
			st_next.s1   = pin;
			st_next.s2   = st_reg.s1;
			st_next.s3   = st_reg.s2;
			st_next.rise = st_reg.s2 & ~st_reg.s3;
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign rise = st_reg.rise;
endmodule

// file: hw/ram_array.sv
// Physical storage array with a bit-masked write port and a registered read port.
// Assumes at most one write per cycle; the caller merges init and user writes.
`timescale 1ns/10ps
module ram_array #(
	parameter int ROWS_P = ram_block_pkg::ROWS,
	parameter int ROW_WP = ram_block_pkg::ROW_W,
	parameter int DATA_P = ram_block_pkg::DATA_W
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	input  wire logic              we,
	input  wire logic [ROW_WP-1:0] wrow,
	input  wire logic [DATA_P-1:0] wmask,
	input  wire logic [DATA_P-1:0] wdata,
	input  wire logic              re,
	input  wire logic [ROW_WP-1:0] rrow,
	output logic      [DATA_P-1:0] rdata
);
	logic [DATA_P-1:0]         mem [ROWS_P];
	ram_block_pkg::mem_state_t st_reg;
	ram_block_pkg::mem_state_t st_next;

	// Read samples the old row, so a same-row write lands afterwards
	always_comb
	begin
		st_next = st_reg;
		if (ce && re)
			st_next.rdata = mem[rrow];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Contents are not cleared: only registers around the array are
	always_ff @(posedge clk)
	begin
		if (ce && we)
			mem[wrow] <= (mem[wrow] & ~wmask) | (wdata & wmask);
	end

	assign rdata = st_reg.rdata;
endmodule

// file: hw/embedded_ram_block.sv
// Configurable 4096-bit RAM/ROM block with optional path registers.
// Assumes user logic on clk drives data, addresses and enables; the two
// section clocks arrive as pins and are sampled into one-cycle ticks.
//
// Notes on behaviour
// R1: Store holds exactly 4096 bits.
// R2: Shapes 256x16, 512x8, 1024x4, 2048x2.
// R3: Words up to 16 bits wide.
// R4: Single-port or dual-port by configuration.
// R5: Dual-port read and write run on separate clocks.
// R6: Each section has its own clock enable.
// R7: Input-side and output-side clock/enable pairs.
// R8: Read address/enable regs pick either clock.
// R9: All registers clear asynchronously.
// R10: Each path may be registered or passed.
// R11: Block makes its own write strobe.
// R12: ROM mode: preloaded pattern, writes ignored.
// R13: Two simultaneous full ports need two blocks.
// R14: Deeper or wider memories cascade blocks outside.
// R15: Write needs write enable and clock enable.
// R16: Idle read holds output; read-during-write returns old.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
module embedded_ram_block (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic                               ce,
	input  wire logic                               clr_n,
	input  wire logic                               in_clk_pin,
	input  wire logic                               out_clk_pin,
	input  wire logic                               inclocken,
	input  wire logic                               outclocken,
	input  wire logic [ram_block_pkg::DATA_W-1:0]   data,
	input  wire logic [ram_block_pkg::ADDR_W-1:0]   wraddr,
	input  wire logic                               wren,
	input  wire logic [ram_block_pkg::ADDR_W-1:0]   rdaddr,
	input  wire logic                               rden,
	input  wire logic [1:0]                         cfg_addr,
	input  wire logic [ram_block_pkg::DATA_W-1:0]   cfg_wdata,
	input  wire logic                               cfg_wr,
	input  wire logic                               cfg_rd,
	output logic      [ram_block_pkg::DATA_W-1:0]   cfg_rdata,
	output logic      [ram_block_pkg::DATA_W-1:0]   q
);
	ram_block_pkg::top_state_t           st_reg;
	ram_block_pkg::top_state_t           st_next;
	logic                                arst_n;
	logic                                in_tick;
	logic                                out_tick;
	logic                                wr_tick;
	logic                                out_reg_tick;
	logic                                rd_addr_tick;
	logic [ram_block_pkg::ADDR_W-1:0]    eff_wraddr;
	logic [ram_block_pkg::DATA_W-1:0]    eff_wdata;
	logic                                eff_wren;
	logic [ram_block_pkg::ADDR_W-1:0]    eff_rdaddr;
	logic                                eff_rden;
	logic                                init_we;
	logic                                user_we;
	logic                                mem_we;
	logic [ram_block_pkg::ROW_W-1:0]     mem_wrow;
	logic [ram_block_pkg::ROW_W-1:0]     user_wrow;
	logic [ram_block_pkg::DATA_W-1:0]    mem_wmask;
	logic [ram_block_pkg::DATA_W-1:0]    mem_wdata;
	logic [ram_block_pkg::ROW_W-1:0]     mem_rrow;
	logic [ram_block_pkg::DATA_W-1:0]    mem_rdata;
	logic [ram_block_pkg::DATA_W-1:0]    q_src;
	logic [3:0]                          wpos;

	// R9: clear from local signal or chip reset
	// Combined clear is glitch-sensitive; drive clr_n from a register.
	assign arst_n = nrst & clr_n;

	// R7: input-side and output-side clocks
	pin_edge_sampler u_in_clk (
		.clk  (clk),
		.nrst (arst_n),
		.ce   (ce),
		.pin  (in_clk_pin),
		.rise (in_tick)
	);

	pin_edge_sampler u_out_clk (
		.clk  (clk),
		.nrst (arst_n),
		.ce   (ce),
		.pin  (out_clk_pin),
		.rise (out_tick)
	);

	// R6: per-section clock enables gate the ticks
	assign wr_tick      = in_tick & inclocken;
	assign out_reg_tick = out_tick & outclocken;
	// R8: read address/enable clock selection
	// R5: in dual-port the read side may follow the output clock
	assign rd_addr_tick = (st_reg.cfg.dual && st_reg.cfg.rd_on_out) ? out_reg_tick : wr_tick;

	// R10: each path is either the held copy or the live input
	always_comb
	begin
		eff_wraddr = st_reg.cfg.regsel[ram_block_pkg::SEL_WRADDR] ? st_reg.wa_h : wraddr;
		eff_wdata  = st_reg.cfg.regsel[ram_block_pkg::SEL_WDATA] ? st_reg.wd_h : data;
		eff_wren   = st_reg.cfg.regsel[ram_block_pkg::SEL_WREN] ? st_reg.we_h : wren;
		eff_rden   = st_reg.cfg.regsel[ram_block_pkg::SEL_RDEN] ? st_reg.re_h : rden;
		// R4: single-port reads at the write address
		if (!st_reg.cfg.dual)
			eff_rdaddr = eff_wraddr;
		else if (st_reg.cfg.regsel[ram_block_pkg::SEL_RDADDR])
			eff_rdaddr = st_reg.ra_h;
		else
			eff_rdaddr = rdaddr;
	end

	// R11: internal strobe one cycle after the write-side tick
	// R15: only with write enable; R12: ROM mode ignores user writes
	assign user_we = st_reg.wr_go & eff_wren & ~st_reg.cfg.rom;
	assign init_we = cfg_wr && (cfg_addr == ram_block_pkg::OFS_INIT_DATA);
	assign mem_we  = init_we | user_we;

	// R2: shape decides row, lane and width of each word
	// Init load wins the port; loading is meant for configuration time.
	always_comb
	begin
		user_wrow = ram_block_pkg::row_of(st_reg.cfg.shape, eff_wraddr);
		wpos      = ram_block_pkg::lane_pos(st_reg.cfg.shape, eff_wraddr);
		if (init_we)
		begin
			mem_wrow  = st_reg.init_row;
			mem_wmask = ram_block_pkg::FULL_MASK;
			mem_wdata = cfg_wdata;
		end
		else
		begin
			mem_wrow  = user_wrow;
			mem_wmask = ram_block_pkg::width_mask(st_reg.cfg.shape) << wpos;
			mem_wdata = (eff_wdata & ram_block_pkg::width_mask(st_reg.cfg.shape)) << wpos;
		end
		mem_rrow = ram_block_pkg::row_of(st_reg.cfg.shape, eff_rdaddr);
	end

	// R1: 256 rows of 16 bits
	// R3: full 16-bit word in one row
	ram_array #(
		.ROWS_P (ram_block_pkg::ROWS),
		.ROW_WP (ram_block_pkg::ROW_W),
		.DATA_P (ram_block_pkg::DATA_W)
	) u_array (
		.clk   (clk),
		.nrst  (arst_n),
		.ce    (ce),
		.we    (mem_we),
		.wrow  (mem_wrow),
		.wmask (mem_wmask),
		.wdata (mem_wdata),
		.re    (eff_rden),
		.rrow  (mem_rrow),
		.rdata (mem_rdata)
	);

	// Word extracted from the row read last
	assign q_src = (mem_rdata >> st_reg.rpos) & ram_block_pkg::width_mask(st_reg.cfg.shape);

	// Next-state logic; everything freezes while ce is low
	always_comb
	begin
		st_next       = st_reg;
		st_next.rdata = ram_block_pkg::WORD_ZERO;
		if (ce)
		begin
			// R10: input-side path registers capture on the write tick
			if (wr_tick)
			begin
				st_next.wa_h = wraddr;
				st_next.wd_h = data;
				st_next.we_h = wren;
			end
			st_next.wr_go = wr_tick;
			// R8: read-side path registers on the selected tick
			if (rd_addr_tick)
			begin
				st_next.ra_h = rdaddr;
				st_next.re_h = rden;
			end
			// R16: idle read keeps the lane with the held row
			if (eff_rden)
				st_next.rpos = ram_block_pkg::lane_pos(st_reg.cfg.shape, eff_rdaddr);
			// R10: output register on the output tick, else follow
			if (!st_reg.cfg.regsel[ram_block_pkg::SEL_DOUT])
				st_next.q = q_src;
			else if (out_reg_tick)
				st_next.q = q_src;
			if (user_we)
				st_next.wr_count = st_reg.wr_count + ram_block_pkg::COUNT_ONE;
			// Configuration port writes
			if (cfg_wr)
			begin
				case (cfg_addr)
					ram_block_pkg::OFS_CFG:
						st_next.cfg = ram_block_pkg::cfg_t'(cfg_wdata[ram_block_pkg::CFG_W-1:0]);
					ram_block_pkg::OFS_INIT_ADDR:
						st_next.init_row = cfg_wdata[ram_block_pkg::ROW_W-1:0];
					// R12: pattern load steps through rows
					ram_block_pkg::OFS_INIT_DATA:
						st_next.init_row = st_reg.init_row + ram_block_pkg::ROW_ONE;
					default:
						st_next.wr_count = ram_block_pkg::WORD_ZERO;
				endcase
			end
			// Read data stand only in the cycle after the strobe
			if (cfg_rd)
			begin
				case (cfg_addr)
					ram_block_pkg::OFS_CFG:
						st_next.rdata = {5'h00, st_reg.cfg};
					ram_block_pkg::OFS_INIT_ADDR:
						st_next.rdata = {8'h00, st_reg.init_row};
					ram_block_pkg::OFS_STATUS:
						st_next.rdata = st_reg.wr_count;
					default:
						st_next.rdata = ram_block_pkg::WORD_ZERO;
				endcase
			end
		end
		else
			st_next.rdata = st_reg.rdata;
	end

	// R9: every register takes its constant on clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg          <= '0;
			st_reg.cfg      <= ram_block_pkg::CFG_RESET;
			st_reg.init_row <= ram_block_pkg::ROW_ZERO;
			st_reg.wa_h     <= ram_block_pkg::ADDR_ZERO;
			st_reg.ra_h     <= ram_block_pkg::ADDR_ZERO;
		end
		else
			st_reg <= st_next;
	end

	assign q         = st_reg.q;
	assign cfg_rdata = st_reg.rdata;

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence wr_capture;
		ce && wr_tick;
	endsequence

	sequence wr_commit;
		st_reg.wr_go ##0 (eff_wren && !st_reg.cfg.rom && !init_we);
	endsequence

	property strobe_follows_tick;
		wr_capture |=> st_reg.wr_go;
	endproperty

	property commit_writes;
		wr_commit |-> mem_we && mem_wrow == user_wrow;
	endproperty

	// Read-side copies load only on the selected tick
	sequence rd_capture;
		ce && rd_addr_tick;
	endsequence

	property wr_copy_taken;
		wr_capture |=> st_reg.wa_h == $past(wraddr) && st_reg.wd_h == $past(data) && st_reg.we_h == $past(wren);
	endproperty

	property rd_copy_taken;
		rd_capture |=> st_reg.ra_h == $past(rdaddr) && st_reg.re_h == $past(rden);
	endproperty

	property row_load_full;
		init_we |-> mem_wrow == st_reg.init_row && &mem_wmask;
	endproperty

	// R11: strobe one cycle after tick
	strobe_after_tick_a: assert property (strobe_follows_tick) else $error("write strobe missed its tick"); // R11
	// R11: committed write reaches array
	commit_reaches_array_a: assert property (commit_writes) else $error("write strobe not applied"); // R11
	// R15: no tick, no write next cycle
	write_needs_tick_a: assert property (ce && !wr_tick && !init_we |=> !user_we) else $error("write without tick"); // R15
	// R12: ROM blocks user writes
	rom_write_block_a: assert property (st_reg.cfg.rom && !init_we |-> !mem_we) else $error("write into rom"); // R12
	// R4: single-port shares one address
	single_port_addr_a: assert property (!st_reg.cfg.dual |-> mem_rrow == user_wrow) else $error("single port split"); // R4
	// R6: registered output held while its enable is low
	out_hold_a: assert property (st_reg.cfg.regsel[ram_block_pkg::SEL_DOUT] && !out_reg_tick |=> $stable(q)) else $error("output moved without tick"); // R6
	// R8: read address register clocked only by chosen tick
	rdaddr_clock_a: assert property (ce && !rd_addr_tick |=> $stable(st_reg.ra_h) && $stable(st_reg.re_h)) else $error("read addr reg moved"); // R8
	// R10: unregistered output follows array next cycle
	out_unreg_a: assert property (ce && !st_reg.cfg.regsel[ram_block_pkg::SEL_DOUT] |=> q == $past(q_src)) else $error("output path not passed"); // R10
	// R2: unregistered output no wider than shape while shape is stable
	q_width_a: assert property (!st_reg.cfg.regsel[ram_block_pkg::SEL_DOUT] && $stable(st_reg.cfg.shape) ##1 $stable(st_reg.cfg.shape) |-> (q & ~ram_block_pkg::width_mask(st_reg.cfg.shape)) == ram_block_pkg::WORD_ZERO) else $error("output wider than shape"); // R2
	// R16: idle read leaves array output alone
	read_idle_hold_a: assert property (ce && !eff_rden |=> $stable(mem_rdata)) else $error("read data moved while idle"); // R16
	// R9: clear leaves output at zero
	clear_value_a: assert property ($rose(arst_n) |-> q == ram_block_pkg::WORD_ZERO) else $error("output not cleared"); // R9
	// R10: write path copies taken at tick
	wr_copy_a: assert property (wr_copy_taken) else $error("write path copy wrong"); // R10
	// R8: read copies follow chosen tick
	rd_copy_a: assert property (rd_copy_taken) else $error("read path copy wrong"); // R8
	// R6: disabled write section ignores tick
	wr_gate_a: assert property (ce && in_tick && !inclocken |=> !st_reg.wr_go) else $error("tick not gated"); // R6
	// R12: pattern load fills whole row
	init_row_load_a: assert property (row_load_full) else $error("load misrouted"); // R12
endmodule

// file: test/section_clock_model.sv
// Model of the user logic that makes the two section clock pins.
// Assumes requests arrive as one-cycle pulses in the system clock domain.
`timescale 1ns/10ps
module section_clock_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic in_req,
	input  wire logic out_req,
	output logic      in_clk_pin,
	output logic      out_clk_pin
);
	logic [2:0] in_cnt;
	logic [2:0] out_cnt;

	// Each request gives one pulse four cycles wide; pins rest low between frames
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_cnt  <= 3'h0;
			out_cnt <= 3'h0;
		end
		else
		begin
			in_cnt  <= in_req ? 3'h4 : in_cnt - {2'h0, in_cnt != 3'h0};
			out_cnt <= out_req ? 3'h4 : out_cnt - {2'h0, out_cnt != 3'h0};
		end
	end

	assign in_clk_pin  = (in_cnt != 3'h0);
	assign out_clk_pin = (out_cnt != 3'h0);
endmodule

// file: test/tb_top.sv
// Self-checking bench for the embedded RAM block.
// Assumes a 25 MHz system clock; section clocks come from the pin model.
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic        sel;
		logic [15:0] v;
	} note_t;

	logic        clk, nrst, clr_n, in_req, out_req, in_clk_pin, out_clk_pin;
	logic        inclocken, outclocken, wren, rden, cfg_wr, cfg_rd, chk;
	logic [15:0] data, cfg_wdata, cfg_rdata, q, got, m;
	logic [10:0] wraddr, rdaddr;
	logic [1:0]  cfg_addr;
	note_t       notes[$];
	note_t       e;
	int          fail_count, total_checks;
	logic [15:0] d [3];
	logic [10:0] a [3];

	always #20 clk = ~clk;

	embedded_ram_block i_embedded_ram_block (.clk(clk), .nrst(nrst), .ce(1'b1), .clr_n(clr_n),
		.in_clk_pin(in_clk_pin), .out_clk_pin(out_clk_pin), .inclocken(inclocken),
		.outclocken(outclocken), .data(data), .wraddr(wraddr), .wren(wren), .rdaddr(rdaddr),
		.rden(rden), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .q(q));

	section_clock_model i_section_clock_model (.clk(clk), .nrst(nrst), .in_req(in_req),
		.out_req(out_req), .in_clk_pin(in_clk_pin), .out_clk_pin(out_clk_pin));

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Note a result that is due in this cycle; sel 1 picks q, 0 picks cfg_rdata
	task automatic expect_now(input logic sel, input logic [15:0] v);
		notes.push_back('{sel, v});
		chk <= 1'b1;
		@(posedge clk) chk <= 1'b0;
	endtask

	task automatic cfg_write(input logic [1:0] ad, input logic [15:0] v);
		@(posedge clk);
		cfg_addr  <= ad;
		cfg_wdata <= v;
		cfg_wr    <= 1'b1;
		@(posedge clk) cfg_wr <= 1'b0;
	endtask

	task automatic cfg_read(input logic [1:0] ad, input logic [15:0] v);
		@(posedge clk);
		cfg_addr <= ad;
		cfg_rd   <= 1'b1;
		@(posedge clk) cfg_rd <= 1'b0;
		expect_now(1'b0, v);
	endtask

	// Inputs settle a full pulse ahead of the tick and stay put past the strobe
	task automatic wr_word(input logic [10:0] ad, input logic [15:0] v, input logic en, input logic ien);
		@(posedge clk);
		wraddr    <= ad;
		data      <= v;
		wren      <= en;
		inclocken <= ien;
		in_req    <= 1'b1;
		@(posedge clk) in_req <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	// one read port only
	// One read port beside the one write port; q is due two cycles after rden
	task automatic rd_word(input logic [10:0] ad, input logic [15:0] v);
		@(posedge clk);
		rdaddr <= ad;
		rden   <= 1'b1;
		@(posedge clk) rden <= 1'b0;
		@(posedge clk);
		expect_now(1'b1, v);
	endtask

	// Monitor: compare each due output against the oldest note
	always @(negedge clk)
	begin
		if (chk === 1'b1)
		begin
			e   = notes.pop_front();
			got = e.sel ? q : cfg_rdata;
			total_checks++;
			if (got !== e.v)
			begin
				$display("Error %s expected %h seen %h", e.sel ? "q" : "cfg_rdata", e.v, got);
				fail_count++;
			end
		end
	end

	// Watchdog so a hang still reaches the report
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end

	initial
	begin
		{clk, nrst, clr_n, in_req, out_req, inclocken, outclocken, wren, rden, cfg_wr, cfg_rd, chk} = '0;
		clr_n = 1'b1;
		{data, cfg_wdata, wraddr, rdaddr, cfg_addr} = '0;
		void'($urandom(5));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		cfg_read(2'h0, 16'h0000);
		// Every shape in dual-port mode: both ends and address 1, a lane neighbour except in 256x16
		for (int s = 0; s < 4; s++)
		begin
			cfg_write(2'h0, 16'h0004 | 16'(s));
			m    = 16'((32'h1 << (16 >> s)) - 1);
			a[0] = 11'h000;
			a[1] = 11'h001;
			a[2] = 11'((256 << s) - 1);
			for (int i = 0; i < 3; i++)
			begin
				d[i] = 16'($urandom);
				wr_word(a[i], d[i], 1'b1, 1'b1);
			end
			for (int i = 0; i < 3; i++)
				rd_word(a[i], d[i] & m);
		end
		// Refused writes: no write enable, then no clock enable
		cfg_write(2'h0, 16'h0004);
		cfg_write(2'h3, 16'h0000);
		wr_word(11'h014, 16'h1234, 1'b1, 1'b1);
		wr_word(11'h015, 16'h5678, 1'b1, 1'b1);
		wr_word(11'h014, 16'hdead, 1'b0, 1'b1);
		wr_word(11'h015, 16'hbeef, 1'b1, 1'b0);
		rd_word(11'h014, 16'h1234);
		rd_word(11'h015, 16'h5678);
		cfg_read(2'h3, 16'h0002);
		repeat (3) @(posedge clk);
		expect_now(1'b1, 16'h5678);
		// Registered output follows only the output-side clock
		cfg_write(2'h0, 16'h0044);
		outclocken <= 1'b1;
		rd_word(11'h014, 16'h5678);
		@(posedge clk) out_req <= 1'b1;
		@(posedge clk) out_req <= 1'b0;
		repeat (8) @(posedge clk);
		expect_now(1'b1, 16'h1234);
		outclocken <= 1'b0;
		rd_word(11'h015, 16'h1234);
		@(posedge clk) out_req <= 1'b1;
		@(posedge clk) out_req <= 1'b0;
		repeat (8) @(posedge clk);
		expect_now(1'b1, 16'h1234);
		// Lookup contents come from the init load; user writes bounce
		cfg_write(2'h0, 16'h000c);
		cfg_write(2'h1, 16'h0030);
		cfg_write(2'h2, 16'ha5c3);
		wr_word(11'h030, 16'h0f0f, 1'b1, 1'b1);
		rd_word(11'h030, 16'ha5c3);
		// Single-port reads follow the write address, not rdaddr
		cfg_write(2'h0, 16'h0000);
		wr_word(11'h005, 16'h9a7e, 1'b1, 1'b1);
		rd_word(11'h030, 16'h9a7e);
		// Local clear in mid-run
		@(posedge clk) clr_n <= 1'b0;
		repeat (2) @(posedge clk);
		clr_n <= 1'b1;
		expect_now(1'b1, 16'h0000);
		cfg_read(2'h0, 16'h0000);
		// Registered paths, read side on the output-side clock; live rden alone must not read
		cfg_write(2'h0, 16'h07b4);
		outclocken <= 1'b1;
		wr_word(11'h022, 16'h3c3c, 1'b1, 1'b1);
		@(posedge clk);
		rdaddr  <= 11'h022;
		rden    <= 1'b1;
		out_req <= 1'b1;
		@(posedge clk) out_req <= 1'b0;
		@(posedge clk);
		expect_now(1'b1, 16'h0000);
		repeat (4) @(posedge clk);
		expect_now(1'b1, 16'h3c3c);
		repeat (2) @(posedge clk);
		close_out();
	end
endmodule
